// file: bench/tb.sv
// Purpose: self-checking bench of the trip value recorder
// Assumes: one sample strobe every 4 cycles stands for 1 ms
// Notes: fault windows shortened to 20 and 40 cycles
`timescale 1ns/1ps
module tb import tvr_pkg::*; ;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  tvr_sample_s [2:0] chanIn = '0;
  logic sampleStrobe = 1'b0;
  logic genStart = 1'b0;
  logic genTrip = 1'b0;
  logic eventReady = 1'b0;
  logic startIn;
  logic tripIn;
  logic eventValid;
  tvr_event_s eventData;
  int bad_count = 0;
  int n_checks = 0;
  int prim[3][$];
  int expVal[6];

  always #2 core_clk = ~core_clk;

  tvr_trip_logic_model i_far (.core_clk(core_clk), .reset(reset), .genStart(genStart),
    .genTrip(genTrip), .startOut(startIn), .tripOut(tripIn));

  trip_value_recorder #(.FAULT1_CYC(20), .FAULT2_CYC(40)) i_dut (.core_clk(core_clk),
    .reset(reset), .chanIn(chanIn), .sampleStrobe(sampleStrobe),
    .recorderStartInput(startIn), .recorderTripInput(tripIn), .eventValid(eventValid),
    .eventReady(eventReady), .eventData(eventData));

  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_bit(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0b seen %0b", what, exp, got);
    end
  endtask

  task automatic chk_ev(tvr_event_s exp, tvr_event_s got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED event expected %h seen %h", exp, got);
    end
  endtask

  // random secondary values kept small so the product never wraps
  task automatic sample();
    tvr_sample_s [2:0] s;
    int v;
    for (int c = 0; c < 3; c++) begin
      v = int'($urandom_range(4000)) - 2000;
      s[c].sec = v[15:0];
      s[c].ratio = 16'($urandom_range(999));
      prim[c].push_back(v * int'(s[c].ratio));
    end
    @(posedge core_clk);
    chanIn <= s;
    sampleStrobe <= 1'b1;
    @(posedge core_clk);
    sampleStrobe <= 1'b0;
    chanIn <= ~s;
    tick(2);
  endtask

  task automatic trip();
    @(posedge core_clk);
    genTrip <= 1'b1;
    tick(2);
    genTrip <= 1'b0;
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge core_clk) chk_bit("idle valid", 1'b0, eventValid);
  endtask

  // strobes placed well clear of the 20 and 40 cycle capture points
  task automatic capture(bit tripMid);
    int n;
    n = prim[0].size();
    for (int c = 0; c < 3; c++) expVal[c] = prim[c][n-100];
    @(posedge core_clk);
    genStart <= 1'b1;
    tick(7);
    sample();
    tick(4);
    genTrip <= tripMid;
    tick(2);
    genTrip <= 1'b0;
    tick(12);
    sample();
    for (int c = 0; c < 3; c++) expVal[3+c] = (prim[c][n] + prim[c][n+1]) >>> 1;
    tick(20);
    genStart <= 1'b0;
    tick(2);
  endtask

  task automatic collect();
    tvr_event_s e;
    int k;
    int w;
    k = 0;
    w = 0;
    while (k < 6 && w < 300) begin
      @(posedge core_clk);
      eventReady <= 1'($urandom_range(1));
      @(negedge core_clk);
      w++;
      if (eventValid === 1'b1 && eventReady === 1'b1) begin
        e.forward = 1'b1;
        e.kind = (k < 3) ? TVR_PREFAULT : TVR_FAULT;
        e.chan = 2'(k % 3);
        e.value = expVal[k];
        chk_ev(e, eventData);
        k++;
      end
    end
    chk_bit("six events", 1'b1, k == 6);
    @(posedge core_clk);
    eventReady <= 1'b0;
    @(negedge core_clk) chk_bit("valid after last", 1'b0, eventValid);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(64));
    tick(2);
    reset <= 1'b0;
    @(negedge core_clk) chk_bit("valid after reset", 1'b0, eventValid);
    trip();
    idle(10);
    repeat (110) sample();
    capture(1'b0);
    repeat (5) sample();
    capture(1'b0);
    idle(5);
    trip();
    collect();
    trip();
    idle(10);
    repeat (3) sample();
    capture(1'b1);
    // a start edge while events are pending must leave the stored values alone
    @(posedge core_clk);
    genStart <= 1'b1;
    tick(3);
    genStart <= 1'b0;
    tick(2);
    collect();
    trip();
    idle(10);
    tally_and_finish();
  end

  // about 730 cycles expected; cut off at 5000
  initial begin
    #20000;
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule // tb

// file: bench/tvr_trip_logic_model.sv
// Purpose: stand-in for the protection start and trip logic
// Assumes: bench asks for general start and general trip as levels
// Notes: outputs are registered, so edges reach the recorder one cycle late
`timescale 1ns/1ps
module tvr_trip_logic_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic genStart,
  input wire logic genTrip,
  output logic startOut,
  output logic tripOut
);
  always_ff @(posedge core_clk) begin
    startOut <= reset ? 1'b0 : genStart;
    tripOut <= reset ? 1'b0 : genTrip;
  end
endmodule // tvr_trip_logic_model

// file: hw/trip_value_recorder.sv
// Purpose: captures prefault and fault values of three channels, reports on trip
// Assumes: start, trip and samples come from logic on core_clk
// Notes: start edges seen while events are being emitted are ignored
`timescale 1ns/1ps
// Contract
// - secondary samples are scaled by ratio to primary values used everywhere
// - every start rising edge outside event emission captures prefault and fault value per channel
// - after capture the recorder waits for the trip input
// - a new start before trip overwrites stored prefault and fault values
// - prefault value is the channel value 100 ms before start
// - fault value averages samples at 10 ms and 20 ms after start
// - trip activation emits events with all stored values
// - events enter local event list and are forwarded without request
// - no binary outputs; only the prefault and fault events
module trip_value_recorder import tvr_pkg::*; #(
  parameter int FAULT1_CYC = TVR_FAULT1_CYC,
  parameter int FAULT2_CYC = TVR_FAULT2_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire tvr_sample_s [2:0] chanIn,
  input wire logic sampleStrobe,
  input wire logic recorderStartInput,
  input wire logic recorderTripInput,
  output logic eventValid,
  input wire logic eventReady,
  output tvr_event_s eventData
);
  // ****************************************
  // declarations
  // ****************************************
  tvr_state_e state_r;
  tvr_state_e state_nxt;
  logic startPrev_r;
  logic tripPrev_r;
  logic tripPend_r;
  logic histWr_r;
  logic [31:0] cnt_r;
  logic [2:0] evIdx_r;
  tvr_event_s evData_r;
  logic signed [31:0] prim_r [TVR_CHANNELS];
  logic signed [31:0] histOld [TVR_CHANNELS];
  logic signed [31:0] pre_r [TVR_CHANNELS];
  logic signed [31:0] faultA_r [TVR_CHANNELS];
  logic signed [31:0] fault_r [TVR_CHANNELS];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ****************************************
  // decode
  // ****************************************
  wire startRise = recorderStartInput & ~startPrev_r;
  wire tripRise = recorderTripInput & ~tripPrev_r;
  // a start during emission would corrupt the values being sent
  wire takeStart = startRise && (state_r != TVR_EMIT);
  wire atFault1 = (state_r == TVR_CAPT) && (cnt_r == 32'(FAULT1_CYC)) && !startRise;
  wire atFault2 = (state_r == TVR_CAPT) && (cnt_r == 32'(FAULT2_CYC)) && !startRise;
  wire evFire = eventValid && eventReady;
  wire lastEv = evFire && (evIdx_r == TVR_LAST_EVENT);
  wire [2:0] nextIdx = (state_r == TVR_EMIT) ? evIdx_r + 3'h1 : 3'h0;
  wire [1:0] nextChan = (nextIdx >= TVR_FIRST_FAULT) ? 2'(nextIdx - TVR_FIRST_FAULT) :
    2'(nextIdx);
  wire nextIsFault = (nextIdx >= TVR_FIRST_FAULT);
  wire loadEv = (state_r != TVR_EMIT && state_nxt == TVR_EMIT) || (evFire && !lastEv);

  assign eventValid = (state_r == TVR_EMIT);
  assign eventData = evData_r;

  // ****************************************
  // channel conversion and history
  // ****************************************
  generate
    for (genvar ch = 0; ch < TVR_CHANNELS; ch++) begin : g_chan
      wire signed [32:0] prod = 33'(chanIn[ch].sec) * 33'($signed({1'b0, chanIn[ch].ratio}));
      wire signed [32:0] sum = 33'(faultA_r[ch]) + 33'(prim_r[ch]);

      always_ff @(posedge core_clk) begin
        if (reset) begin
          prim_r[ch] <= 32'sh0;
          pre_r[ch] <= 32'sh0;
          faultA_r[ch] <= 32'sh0;
          fault_r[ch] <= 32'sh0;
        end else begin
          if (sampleStrobe) begin
            prim_r[ch] <= 32'(prod);
          end
          if (takeStart) begin
            pre_r[ch] <= histOld[ch];
          end
          if (atFault1) begin
            faultA_r[ch] <= prim_r[ch];
          end
          if (atFault2) begin
            fault_r[ch] <= 32'(sum >>> 1);
          end
        end
      end

      tvr_history u_hist (
        .core_clk(core_clk),
        .reset(reset),
        .wrEn(histWr_r),
        .wrData(prim_r[ch]),
        .oldData(histOld[ch])
      );
    end
  endgenerate

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TVR_IDLE: begin
        if (startRise) begin
          state_nxt = TVR_CAPT;
        end
      end
      TVR_CAPT: begin
        if (atFault2) begin
          state_nxt = (tripPend_r || tripRise) ? TVR_EMIT : TVR_ARMED;
        end
      end
      TVR_ARMED: begin
        if (startRise) begin
          state_nxt = TVR_CAPT;
        end else if (tripRise) begin
          state_nxt = TVR_EMIT;
        end
      end
      TVR_EMIT: begin
        if (lastEv) begin
          state_nxt = TVR_IDLE;
        end
      end
      default: begin
        state_nxt = TVR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= TVR_IDLE;
      startPrev_r <= 1'b0;
      tripPrev_r <= 1'b0;
      histWr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      startPrev_r <= recorderStartInput;
      tripPrev_r <= recorderTripInput;
      histWr_r <= sampleStrobe;
    end
  end

  // trip arriving before the fault window closes is held until it does;
  // a trip landing with a restart during capture is kept, else its events would be lost
  always_ff @(posedge core_clk) begin
    if (reset || state_r != TVR_CAPT) begin
      tripPend_r <= 1'b0;
    end else if (tripRise) begin
      tripPend_r <= 1'b1;
    end else if (takeStart) begin
      tripPend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || takeStart) begin
      cnt_r <= 32'h0;
    end else if (state_r == TVR_CAPT) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // ****************************************
  // event output
  // ****************************************
  // step through six stored values
  always_ff @(posedge core_clk) begin
    if (reset) begin
      evIdx_r <= 3'h0;
      evData_r <= '0;
    end else if (loadEv) begin
      evIdx_r <= nextIdx;
      evData_r.forward <= 1'b1;
      evData_r.kind <= nextIsFault ? TVR_FAULT : TVR_PREFAULT;
      evData_r.chan <= nextChan;
      evData_r.value <= nextIsFault ? fault_r[nextChan] : pre_r[nextChan];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_armedTrip;
    state_r == TVR_ARMED && tripRise && !startRise;
  endsequence
  sequence s_firstEvent;
    eventValid && eventData.kind == TVR_PREFAULT && eventData.chan == 2'h0;
  endsequence

  property p_prim;
    sampleStrobe |=> prim_r[0] == 32'($past(g_chan[0].prod));
  endproperty
  a_prim: assert property (p_prim) else $error("primary value not scaled");
  property p_capt;
    startRise && state_r != TVR_EMIT |=> state_r == TVR_CAPT && cnt_r == 32'h0;
  endproperty
  a_capt: assert property (p_capt) else $error("start edge did not begin capture");
  property p_wait;
    atFault2 && !tripPend_r && !tripRise |=> state_r == TVR_ARMED;
  endproperty
  a_wait: assert property (p_wait) else $error("not waiting for trip");
  property p_restart;
    state_r == TVR_ARMED && startRise |=> state_r == TVR_CAPT ##1 cnt_r == 32'h1;
  endproperty
  a_restart: assert property (p_restart) else $error("new start did not restart");
  property p_pre;
    takeStart |=> pre_r[1] == $past(histOld[1]);
  endproperty
  a_pre: assert property (p_pre) else $error("prefault not taken from history");
  property p_fault;
    atFault2 |=> fault_r[2] == 32'((33'($past(faultA_r[2])) + 33'($past(prim_r[2]))) >>> 1);
  endproperty
  a_fault: assert property (p_fault) else $error("fault average wrong");
  property p_emit;
    s_armedTrip |=> s_firstEvent;
  endproperty
  a_emit: assert property (p_emit) else $error("trip did not emit prefault event");
  property p_fwd;
    eventValid |-> eventData.forward;
  endproperty
  a_fwd: assert property (p_fwd) else $error("event not marked for forwarding");
  property p_last;
    lastEv |-> eventData.kind == TVR_FAULT && eventData.chan == 2'h2 ##1 !eventValid;
  endproperty
  a_last: assert property (p_last) else $error("event sequence end wrong");
  property p_hold;
    eventValid && !eventReady |=> eventValid && $stable(eventData);
  endproperty
  a_hold: assert property (p_hold) else $error("event changed before accept");
endmodule // trip_value_recorder

// file: hw/tvr_history.sv
// Purpose: rolling history of one channel's primary values
// Assumes: one write per channel sample
// Notes: reads zero until a full prefault window has been seen
`timescale 1ns/1ps
module tvr_history import tvr_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic signed [31:0] wrData,
  output logic signed [31:0] oldData
);
  logic signed [31:0] mem [2**TVR_HIST_AW];
  logic [TVR_HIST_AW-1:0] wrPtr_r;
  logic [TVR_HIST_AW-1:0] fill_r;
  wire [TVR_HIST_AW-1:0] rdPtr = wrPtr_r - TVR_PRE_SAMPLES;
  wire full = (fill_r == TVR_PRE_SAMPLES);

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrPtr_r] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_r <= '0;
      fill_r <= '0;
    end else if (wrEn) begin
      wrPtr_r <= wrPtr_r + TVR_HIST_AW'(1);
      if (!full) begin
        fill_r <= fill_r + TVR_HIST_AW'(1);
      end
    end
  end

  assign oldData = full ? mem[rdPtr] : 32'sh0;

  property p_fill;
    @(posedge core_clk) disable iff (reset)
      wrEn && !full |=> fill_r == $past(fill_r) + TVR_HIST_AW'(1);
  endproperty
  a_fill: assert property (p_fill) else $error("history fill did not advance");
endmodule // tvr_history

// file: include/tvr_pkg.sv
// Purpose: shared constants and types of the trip value recorder
// Assumes: 250 MHz core clock, channel samples every TVR_SAMPLE_US
// Notes: all timing counts derive from printed times and the clock rate
package tvr_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int TVR_CLK_MHZ = 250;
  localparam int TVR_SAMPLE_US = 1000;
  localparam int TVR_PRE_TIME_MS = 100;
  localparam int TVR_FAULT1_TIME_MS = 10;
  localparam int TVR_FAULT2_TIME_MS = 20;
  localparam int TVR_FAULT1_CYC = TVR_FAULT1_TIME_MS * 1000 * TVR_CLK_MHZ;
  localparam int TVR_FAULT2_CYC = TVR_FAULT2_TIME_MS * 1000 * TVR_CLK_MHZ;
  localparam int TVR_HIST_AW = 7;
  localparam logic [TVR_HIST_AW-1:0] TVR_PRE_SAMPLES =
    TVR_HIST_AW'(TVR_PRE_TIME_MS * 1000 / TVR_SAMPLE_US);
  // ****************************************
  // event sequencing
  // ****************************************
  localparam int TVR_CHANNELS = 3;
  localparam logic [2:0] TVR_LAST_EVENT = 3'h5;
  localparam logic [2:0] TVR_FIRST_FAULT = 3'h3;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    TVR_IDLE = 2'h0,
    TVR_CAPT = 2'h1,
    TVR_ARMED = 2'h3,
    TVR_EMIT = 2'h2
  } tvr_state_e;
  typedef enum logic {
    TVR_PREFAULT = 1'h0,
    TVR_FAULT = 1'h1
  } tvr_kind_e;
  typedef struct packed {
    logic signed [15:0] sec;
    logic [15:0] ratio;
  } tvr_sample_s;
  typedef struct packed {
    logic forward;
    tvr_kind_e kind;
    logic [1:0] chan;
    logic signed [31:0] value;
  } tvr_event_s;
endpackage
